//--- inc/hof_consts.vh
// constants for the hdr output compander / formatter
// assumes a 100 MHz system clock and a byte-wide register space on the serial control port
`ifndef HOF_CONSTS_VH
`define HOF_CONSTS_VH
`define HOF_DEV_ADDR 7'h10
`define HOF_A_TOP_EMB 16'h430D
`define HOF_A_BOT_EMB 16'h430E
`define HOF_A_STATS 16'h430F
`define HOF_A_ATEST 16'h4310
`define HOF_A_COLID 16'h4311
`define HOF_A_DTEST 16'h4318
`define HOF_A_FORMAT 16'h431F
`define HOF_A_LINK0 16'h4800
`define HOF_A_PERIOD 16'h4837
`define HOF_A_ISP 16'h5002
`define HOF_A_KNEE_FIRST 16'h5E01
`define HOF_A_KNEE_LAST 16'h5E84
`define HOF_RST_TOP_EMB 8'h13
`define HOF_RST_BOT_EMB 8'h14
`define HOF_RST_STATS 8'h17
`define HOF_RST_ATEST 8'h15
`define HOF_RST_COLID 8'h16
`define HOF_RST_DTEST 8'h12
`define HOF_RST_FORMAT 8'h00
`define HOF_RST_LINK0 8'h04
`define HOF_RST_PERIOD 8'h07
`define HOF_RST_ISP 8'h3F
`define HOF_FMT_PACK_HI 7
`define HOF_FMT_PACK_LO 6
`define HOF_FMT_CMP_EN 5
`define HOF_FMT_W_HI 4
`define HOF_FMT_W_LO 3
`define HOF_LINK0_CLK_INV 2
`define HOF_YMAX_12 20'h00FFF
`define HOF_YMAX_14 20'h03FFF
`define HOF_YMAX_16 20'h0FFFF
`define HOF_YMAX_20 20'hFFFFF
`define HOF_DT_RAW8 6'h2A
`define HOF_DT_RAW10 6'h2B
`define HOF_DT_RAW12 6'h2C
`define HOF_DT_RAW14 6'h2D
`define HOF_DT_RAW16 6'h2E
`define HOF_DT_RAW20 6'h30
`define HOF_DT_RAW24 6'h27
`define HOF_DT_FS 6'h00
`define HOF_DT_FE 6'h01
`define HOF_VC_MAIN 2'h0
`define HOF_VC_SECOND 2'h1
`define HOF_ROW_PIXELS 13'h0784
`define HOF_FRAME_ROWS 11'h0510
`endif

//--- src/hof_formatter.v
// hdr output compander and packet formatter, with its input fifo
// assumes combined pixels arrive on clk_sys; control port pins come from another domain
`timescale 1ns/1ns
`include "hof_consts.vh"

module hof_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp;
  reg [AW:0] rp;
  wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = (wp != rp);
  assign out_data = mem[rp[AW-1:0]];
  always @(posedge clk_sys) begin
    if (in_valid && !full)
      mem[wp[AW-1:0]] <= in_data;
    if (!rst_b) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp <= wp + 1'b1;
      if (out_ready && (wp != rp))
        rp <= rp + 1'b1;
    end
  end
endmodule

// Summary of operation
// - each gain capture entering the combine is a 10-bit linear sample
// - three-capture mode yields one uncompanded linear 20-bit pixel
// - four-capture mode adds the small photodiode, giving 24-bit pixels
// - compander reduces 24 bits to 20/16/14/12 or 20 bits to 16/14/12
// - compander curve has up to 33 programmable knee points
// - compander active only when its enable bit is one, for every mode
// - segment output is lower Y plus linear interpolation toward upper Y
// - knee X spacing is a power of two, knee Y values programmable
// - width field selects final knee Y: 4095, 16383, 65535 or 1048575
// - knee parameters live in registers 0x5E01 through 0x5E84
// - two-bit field picks one of four byte packings for 24-bit pixels
// - combined image goes on virtual channel 0
// - flicker bit frame goes on channel 1 as RAW-8, replacement enabled
// - small photodiode frame goes on channel 1 as RAW-10, replacement disabled
// - photodiode word is bits 9..2, then flicker bit, then zero
// - each virtual channel has its own frame start and frame end packets
// - bytes spread over 1, 2 or 4 lanes; packet layout lane independent
// - full frame is 1924 pixels by 1296 rows
// - every row header carries a 6-bit data type, programmable for non-image rows only
// - active rows use fixed types 2C, 2D, 2E, 30, 27 for RAW12/14/16/20/24
// - non-image rows take data types from their 6-bit register fields
// - clock-inversion bit of the first link control register inverts output clock
module hof_formatter (
  input wire clk_sys,
  input wire rst_b,
  input wire ctl_scl,
  input wire ctl_sda_in,
  output reg ctl_sda_out,
  output reg ctl_sda_oe,
  input wire [23:0] pix_data,
  input wire [9:0] pix_small_pd,
  input wire pix_flicker,
  input wire pix_sof,
  input wire pix_eol,
  input wire pix_eof,
  input wire [2:0] pix_row_kind,
  input wire pix_valid,
  output wire pix_ready,
  input wire four_capture_mode,
  input wire [1:0] second_frame_mode,
  input wire [1:0] lane_mode,
  output reg [7:0] lane_byte,
  output reg [1:0] lane_index,
  output reg lane_valid,
  output reg link_clk_out,
  output reg flicker_replace_en
);
  localparam SP_IDLE = 3'd0, SP_DEV = 3'd1, SP_AH = 3'd2, SP_AL = 3'd3, SP_WR = 3'd4, SP_RD = 3'd5;
  localparam PK_IDLE = 3'd0, PK_SHORT = 3'd1, PK_HDR = 3'd2, PK_PAY = 3'd3, PK_FTR = 3'd4;
  localparam SEC_FLICKER = 2'd1, SEC_SMALL_PD = 2'd2;

  reg [7:0] top_emb_type, bot_emb_type, stats_type, atest_type, colid_type, dtest_type;
  reg [7:0] format_ctl, link_ctl0, clk_period, isp_enables;
  reg [7:0] knee [0:131];
  // control port: both pins pass two flops before any logic looks at them
  reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  reg [2:0] sp_st;
  reg [3:0] bitc;
  reg [7:0] sh, tx;
  reg [15:0] addr;
  reg [7:0] rdata;
  integer i;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire sp_start = scl_s && sda_d && !sda_s;
  wire sp_stop = scl_s && !sda_d && sda_s;
  wire wr_en = scl_fall && (bitc == 4'd8) && (sp_st == SP_WR);
  wire in_knee = (addr >= `HOF_A_KNEE_FIRST) && (addr <= `HOF_A_KNEE_LAST);
  wire [15:0] knee_off = addr - `HOF_A_KNEE_FIRST;

  always @* begin
    rdata = 8'h00;
    case (addr)
      `HOF_A_TOP_EMB: rdata = top_emb_type;
      `HOF_A_BOT_EMB: rdata = bot_emb_type;
      `HOF_A_STATS: rdata = stats_type;
      `HOF_A_ATEST: rdata = atest_type;
      `HOF_A_COLID: rdata = colid_type;
      `HOF_A_DTEST: rdata = dtest_type;
      `HOF_A_FORMAT: rdata = format_ctl;
      `HOF_A_LINK0: rdata = link_ctl0;
      `HOF_A_PERIOD: rdata = clk_period;
      `HOF_A_ISP: rdata = isp_enables;
      default: if (in_knee) rdata = knee[knee_off[7:0]];
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
      sp_st <= SP_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      addr <= 16'h0000;
      ctl_sda_out <= 1'b0;
      ctl_sda_oe <= 1'b0;
    end else begin
      scl_m <= ctl_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= ctl_sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      if (sp_start) begin
        sp_st <= SP_DEV;
        bitc <= 4'h0;
        ctl_sda_oe <= 1'b0;
      end else if (sp_stop) begin
        sp_st <= SP_IDLE;
        ctl_sda_oe <= 1'b0;
      end else if (scl_rise && sp_st != SP_IDLE) begin
        if (bitc < 4'd8)
          sh <= {sh[6:0], sda_s};
        if (bitc == 4'd8 && sp_st == SP_RD && sda_s)
          sp_st <= SP_IDLE;
        bitc <= bitc + 4'd1;
      end else if (scl_fall && sp_st != SP_IDLE) begin
        if (bitc == 4'd8) begin
          ctl_sda_oe <= (sp_st != SP_RD);
          case (sp_st)
            SP_DEV: if (sh[7:1] != `HOF_DEV_ADDR) begin
              sp_st <= SP_IDLE;
              ctl_sda_oe <= 1'b0;
            end
            SP_AH: addr[15:8] <= sh;
            SP_AL: addr[7:0] <= sh;
            SP_RD: addr <= addr + 16'h0001;
            default: ;
          endcase
        end else if (bitc == 4'd9) begin
          bitc <= 4'h0;
          ctl_sda_oe <= 1'b0;
          case (sp_st)
            SP_DEV: sp_st <= sh[0] ? SP_RD : SP_AH;
            SP_AH: sp_st <= SP_AL;
            SP_AL: sp_st <= SP_WR;
            SP_WR: addr <= addr + 16'h0001;
            default: ;
          endcase
          if ((sp_st == SP_DEV && sh[0]) || sp_st == SP_RD) begin
            tx <= rdata;
            ctl_sda_oe <= !rdata[7];
          end
        end else if (sp_st == SP_RD && bitc != 4'h0) begin
          ctl_sda_oe <= !tx[6];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      top_emb_type <= `HOF_RST_TOP_EMB;
      bot_emb_type <= `HOF_RST_BOT_EMB;
      stats_type <= `HOF_RST_STATS;
      atest_type <= `HOF_RST_ATEST;
      colid_type <= `HOF_RST_COLID;
      dtest_type <= `HOF_RST_DTEST;
      format_ctl <= `HOF_RST_FORMAT;
      link_ctl0 <= `HOF_RST_LINK0;
      clk_period <= `HOF_RST_PERIOD;
      isp_enables <= `HOF_RST_ISP;
      for (i = 0; i < 132; i = i + 1)
        knee[i] <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `HOF_A_TOP_EMB: top_emb_type <= sh;
        `HOF_A_BOT_EMB: bot_emb_type <= sh;
        `HOF_A_STATS: stats_type <= sh;
        `HOF_A_ATEST: atest_type <= sh;
        `HOF_A_COLID: colid_type <= sh;
        `HOF_A_DTEST: dtest_type <= sh;
        `HOF_A_FORMAT: format_ctl <= sh;
        `HOF_A_LINK0: link_ctl0 <= sh;
        `HOF_A_PERIOD: clk_period <= sh;
        `HOF_A_ISP: isp_enables <= sh;
        default: if (in_knee) knee[knee_off[7:0]] <= sh;
      endcase
    end
  end

  // pixel fifo; the packetizer pops only when the output lane is ready for more bits
  // word: kind[40:38] sof[37] eol[36] eof[35] flicker[34] small pd[33:24] pixel[23:0]
  wire [40:0] ff_out;
  wire ff_valid;
  reg ff_pop;
  hof_fifo #(.WIDTH(41), .DEPTH(16), .AW(4)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_data({pix_row_kind, pix_sof, pix_eol, pix_eof, pix_flicker, pix_small_pd, pix_data}),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .out_data(ff_out),
    .out_valid(ff_valid),
    .out_ready(ff_pop)
  );

  // frame-level settings, latched only when a frame starts
  reg cmp_en, four_f;
  reg [1:0] cmp_w, pack_sel, sec_mode;
  reg [19:0] ymax;
  always @* begin
    case (cmp_w)
      2'd0: ymax = `HOF_YMAX_12;
      2'd1: ymax = `HOF_YMAX_14;
      2'd2: ymax = `HOF_YMAX_16;
      default: ymax = `HOF_YMAX_20;
    endcase
  end

  // knee k: byte 4k holds the log2 span of segment k, bytes 4k+1..4k+3 hold Y[k] for k below 32
  wire [24:0] kx [0:32];
  wire [19:0] ky [0:32];
  wire [4:0] ke [0:32];
  assign kx[0] = 25'h0000000;
  genvar g;
  generate
    for (g = 0; g < 33; g = g + 1) begin : g_knee
      assign ke[g] = knee[4*g][4:0];
      assign ky[g] = (g == 32) ? ymax : {knee[4*g+1][3:0], knee[4*g+2], knee[4*g+3]};
      if (g > 0) begin : g_x
        assign kx[g] = kx[g-1] + (25'h0000001 << ke[g]);
      end
    end
  endgenerate

  wire [23:0] lin = four_f ? ff_out[23:0] : {4'h0, ff_out[19:0]};
  reg [5:0] seg;
  reg [24:0] dx;
  reg [20:0] dy;
  reg [45:0] prod;
  reg [20:0] cmp_sum;
  reg [19:0] cmp_out;
  integer k;
  always @* begin
    seg = 6'd1;
    for (k = 1; k < 32; k = k + 1)
      if ({1'b0, lin} >= kx[k])
        seg = k[5:0] + 6'd1;
    dx = {1'b0, lin} - kx[seg - 6'd1];
    dy = {1'b0, ky[seg]} - {1'b0, ky[seg - 6'd1]};
    prod = ({21'h0, dx} * {25'h0, dy}) >> ke[seg];
    cmp_sum = {1'b0, ky[seg - 6'd1]} + prod[20:0];
    if ({1'b0, lin} >= kx[32] || prod[45:21] != 25'h0 || cmp_sum > {1'b0, ymax})
      cmp_out = ymax;
    else
      cmp_out = cmp_sum[19:0];
  end

  // width of the main pixel on the wire and its row data type
  reg [4:0] pw;
  reg [5:0] dt_main;
  always @* begin
    if (cmp_en)
      case (cmp_w)
        2'd0: pw = 5'd12;
        2'd1: pw = 5'd14;
        2'd2: pw = 5'd16;
        default: pw = 5'd20;
      endcase
    else
      pw = four_f ? 5'd24 : 5'd20;
    case (pw)
      5'd12: dt_main = `HOF_DT_RAW12;
      5'd14: dt_main = `HOF_DT_RAW14;
      5'd16: dt_main = `HOF_DT_RAW16;
      5'd20: dt_main = `HOF_DT_RAW20;
      default: dt_main = `HOF_DT_RAW24;
    endcase
  end

  reg [23:0] main_pix;
  always @* begin
    main_pix = cmp_en ? ({4'h0, cmp_out} << (5'd24 - pw)) : (lin << (5'd24 - pw));
    if (pw == 5'd24)
      case (pack_sel)
        2'd0: main_pix = lin;
        2'd1: main_pix = {lin[7:0], lin[15:8], lin[23:16]};
        2'd2: main_pix = {lin[15:8], lin[7:0], lin[23:16]};
        default: main_pix = {lin[23:16], lin[7:0], lin[15:8]};
      endcase
  end

  // packetizer: one byte per period of the output clock
  reg [2:0] pk_st;
  reg sec, frame_open, row_done, row_eof, tick, is_fe;
  reg [2:0] row_kind;
  reg [7:0] div;
  reg [12:0] bcnt, sec_wr, sec_rd;
  reg [47:0] acc;
  reg [5:0] accn;
  reg [9:0] row_mem [0:2047];
  reg [1:0] lane_ctr;
  wire [1:0] lane_last = (lane_mode == 2'd0) ? 2'd0 : (lane_mode == 2'd1) ? 2'd1 : 2'd3;
  wire [9:0] sec_word = (sec_mode == SEC_SMALL_PD) ? {row_mem[sec_rd[10:0]][9:2], row_mem[sec_rd[10:0]][1], 1'b0}
    : {row_mem[sec_rd[10:0]][1], 7'h00, 2'b00};
  wire [4:0] sw = (sec_mode == SEC_SMALL_PD) ? 5'd10 : 5'd8;
  wire [4:0] cw = sec ? sw : pw;
  wire [7:0] di = {sec ? `HOF_VC_SECOND : `HOF_VC_MAIN,
    (pk_st == PK_SHORT) ? (is_fe ? `HOF_DT_FE : `HOF_DT_FS) : (sec ? (sw == 5'd10 ? `HOF_DT_RAW10 : `HOF_DT_RAW8)
    : (row_kind == 3'd1) ? top_emb_type[5:0] : (row_kind == 3'd2) ? bot_emb_type[5:0]
    : (row_kind == 3'd3) ? stats_type[5:0] : (row_kind == 3'd4) ? dtest_type[5:0]
    : (row_kind == 3'd5) ? atest_type[5:0] : (row_kind == 3'd6) ? colid_type[5:0] : dt_main)};
  wire [31:0] wc_full = ({19'h0, `HOF_ROW_PIXELS} * {27'h0, cw}) >> 3;
  wire need = (accn < 6'd8) && !row_done;
  wire have = sec ? (sec_rd != sec_wr) : ff_valid;
  wire [23:0] src = sec ? {sec_word, 14'h0} : main_pix;
  wire [47:0] acc_m = (need && have) ? (acc | ({src, 24'h0} >> accn)) : acc;
  wire [7:0] short_b = (bcnt == 13'd0) ? di : 8'h00;
  wire [7:0] hdr_b = (bcnt == 13'd0) ? di : (bcnt == 13'd1) ? wc_full[7:0] : (bcnt == 13'd2) ? wc_full[15:8] : 8'h00;

  always @* begin
    ff_pop = tick && pk_st == PK_PAY && !sec && need && ff_valid;
  end

  always @(posedge clk_sys) begin
    if (ff_pop)
      row_mem[sec_wr[10:0]] <= {ff_out[33:26], ff_out[34], 1'b0};
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pk_st <= PK_IDLE;
      {sec, frame_open, row_done, row_eof, tick, is_fe} <= 6'h00;
      {cmp_en, four_f, cmp_w, pack_sel, sec_mode} <= 8'h00;
      row_kind <= 3'd0;
      div <= 8'h00;
      bcnt <= 13'h0;
      sec_wr <= 13'h0;
      sec_rd <= 13'h0;
      acc <= 48'h0;
      accn <= 6'h0;
      lane_ctr <= 2'd0;
      lane_byte <= 8'h00;
      lane_index <= 2'd0;
      lane_valid <= 1'b0;
      link_clk_out <= 1'b0;
      flicker_replace_en <= 1'b0;
    end else begin
      tick <= (div == 8'h00);
      div <= (div == 8'h00) ? clk_period : div - 8'h01;
      if (div == 8'h00 || div == {1'b0, clk_period[7:1]})
        link_clk_out <= (div == 8'h00) ^ link_ctl0[`HOF_LINK0_CLK_INV];
      lane_valid <= 1'b0;
      if (tick) begin
        case (pk_st)
          PK_IDLE: if (ff_valid) begin
            sec <= 1'b0;
            bcnt <= 13'h0;
            row_kind <= ff_out[40:38];
            if (ff_out[37] && !frame_open) begin
              cmp_en <= format_ctl[`HOF_FMT_CMP_EN];
              cmp_w <= format_ctl[`HOF_FMT_W_HI:`HOF_FMT_W_LO];
              pack_sel <= format_ctl[`HOF_FMT_PACK_HI:`HOF_FMT_PACK_LO];
              four_f <= four_capture_mode;
              sec_mode <= second_frame_mode;
              flicker_replace_en <= (second_frame_mode == SEC_FLICKER);
              is_fe <= 1'b0;
              pk_st <= PK_SHORT;
            end else begin
              sec_wr <= 13'h0;
              pk_st <= PK_HDR;
            end
          end
          PK_SHORT: begin
            lane_byte <= short_b;
            bcnt <= bcnt + 13'd1;
            if (bcnt == 13'd3) begin
              bcnt <= 13'h0;
              if (!sec && (sec_mode == SEC_FLICKER || sec_mode == SEC_SMALL_PD))
                sec <= 1'b1;
              else begin
                frame_open <= !is_fe;
                pk_st <= PK_IDLE;
              end
            end
          end
          PK_HDR: begin
            lane_byte <= hdr_b;
            bcnt <= bcnt + 13'd1;
            if (bcnt == 13'd3) begin
              {row_done, acc, accn, sec_rd} <= 68'h0;
              pk_st <= PK_PAY;
            end
          end
          PK_PAY: if (accn >= 6'd8 || (need && have)) begin
            lane_byte <= acc_m[47:40];
            acc <= acc_m << 8;
            accn <= accn + ((need && have) ? {1'b0, cw} : 6'd0) - 6'd8;
            if (need && have && sec)
              sec_rd <= sec_rd + 13'd1;
            if (need && have && !sec) begin
              sec_wr <= sec_wr + 13'd1;
              row_done <= ff_out[36];
              row_eof <= ff_out[35] & ff_out[36];
            end
            if (need && have && sec && sec_rd + 13'd1 == sec_wr)
              row_done <= 1'b1;
            if (accn + ((need && have) ? {1'b0, cw} : 6'd0) == 6'd8 && (row_done || (need && have
                && (sec ? (sec_rd + 13'd1 == sec_wr) : ff_out[36])))) begin
              bcnt <= 13'h0;
              pk_st <= PK_FTR;
            end
          end
          PK_FTR: begin
            lane_byte <= 8'h00;
            bcnt <= bcnt + 13'd1;
            if (bcnt == 13'd1) begin
              bcnt <= 13'h0;
              if (!sec && (sec_mode == SEC_FLICKER || sec_mode == SEC_SMALL_PD)) begin
                sec <= 1'b1;
                pk_st <= PK_HDR;
              end else if (row_eof) begin
                sec <= 1'b0;
                is_fe <= 1'b1;
                pk_st <= PK_SHORT;
              end else
                pk_st <= PK_IDLE;
            end
          end
          default: pk_st <= PK_IDLE;
        endcase
        if (pk_st == PK_SHORT || pk_st == PK_HDR || pk_st == PK_FTR
            || (pk_st == PK_PAY && (accn >= 6'd8 || (need && have)))) begin
          lane_valid <= 1'b1;
          lane_index <= (pk_st != PK_PAY && pk_st != PK_FTR && bcnt == 13'd0) ? 2'd0 : lane_ctr;
          lane_ctr <= ((pk_st != PK_PAY && pk_st != PK_FTR && bcnt == 13'd0) ? 2'd0 : lane_ctr) == lane_last
            ? 2'd0 : ((pk_st != PK_PAY && pk_st != PK_FTR && bcnt == 13'd0) ? 2'd1 : lane_ctr + 2'd1);
        end
      end
    end
  end
endmodule

//--- bench/hof_formatter_chk.sv
// port assertions for the hdr output formatter
// assumes a single clk_sys domain with synchronous active-low rst_b
`timescale 1ns/1ns
module hof_formatter_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ctl_scl,
  input wire logic ctl_sda_out,
  input wire logic ctl_sda_oe,
  input wire logic pix_sof,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [1:0] second_frame_mode,
  input wire logic [1:0] lane_mode,
  input wire logic [7:0] lane_byte,
  input wire logic [1:0] lane_index,
  input wire logic lane_valid,
  input wire logic link_clk_out,
  input wire logic flicker_replace_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_sda_open_drain: assert property (ctl_sda_oe |-> ctl_sda_out == 1'b0)
    else $error("control data driven high");
  // the answer may only move while the host holds the clock low
  a_sda_scl_low: assert property ($changed(ctl_sda_oe) |-> !ctl_scl)
    else $error("control data moved with clock high");
  a_byte_hold: assert property (!lane_valid |-> $stable(lane_byte) && $stable(lane_index))
    else $error("output byte moved without a pulse");
  a_one_lane: assert property (lane_valid && lane_mode == 2'h0 |-> lane_index == 2'h0)
    else $error("byte off lane zero in one-lane mode");
  a_flk_mode: assert property ($rose(flicker_replace_en) |-> second_frame_mode == 2'h1)
    else $error("replacement enabled outside flicker mode");
  a_clk_high: assert property ($rose(link_clk_out) |-> ##[1:256] $fell(link_clk_out))
    else $error("link clock stuck high");
  a_clk_low: assert property ($fell(link_clk_out) |-> ##[1:256] $rose(link_clk_out))
    else $error("link clock stuck low");
  a_sof_start: assert property (pix_valid && pix_ready && pix_sof |->
    ##[1:60] (lane_valid && lane_byte == 8'h00 && lane_index == 2'h0))
    else $error("no frame start after first pixel");
endmodule

bind hof_formatter hof_formatter_chk u_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .ctl_scl(ctl_scl),
  .ctl_sda_out(ctl_sda_out),
  .ctl_sda_oe(ctl_sda_oe),
  .pix_sof(pix_sof),
  .pix_valid(pix_valid),
  .pix_ready(pix_ready),
  .second_frame_mode(second_frame_mode),
  .lane_mode(lane_mode),
  .lane_byte(lane_byte),
  .lane_index(lane_index),
  .lane_valid(lane_valid),
  .link_clk_out(link_clk_out),
  .flicker_replace_en(flicker_replace_en)
);

//--- bench/hof_rx_model.sv
// receiver model for the formatter's byte output
// assumes one byte per lane_valid pulse, kept with its lane number
`timescale 1ns/1ns
module hof_rx_model (
  input wire logic clk_sys,
  input wire logic [7:0] lane_byte,
  input wire logic [1:0] lane_index,
  input wire logic lane_valid
);
  // arrival order is kept so checks can index packets by byte offset
  logic [9:0] q[$];
  always @(posedge clk_sys) begin
    if (lane_valid === 1'b1) begin
      q.push_back({lane_index, lane_byte});
    end
  end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the hdr output formatter
// assumes the receiver model records every output byte in order
`timescale 1ns/1ns
`include "hof_consts.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ctl_scl = 1'b1;
  logic host_sda = 1'b1;
  logic [23:0] pix_data = 24'h000000;
  logic [9:0] pix_small_pd = 10'h2A5;
  logic pix_flicker = 1'b1;
  logic pix_sof = 1'b0;
  logic pix_eol = 1'b0;
  logic pix_valid = 1'b0;
  logic [2:0] pix_row_kind = 3'h0;
  logic four_capture_mode = 1'b0;
  logic [1:0] second_frame_mode = 2'h0;
  logic [1:0] lane_mode = 2'h0;
  logic ctl_sda_out, ctl_sda_oe, pix_ready, lane_valid, link_clk_out, flicker_replace_en;
  logic [7:0] lane_byte;
  logic [1:0] lane_index;
  // open-drain wire with pull-up: low whenever either side pulls
  wire sda_wire = ctl_sda_oe ? 1'b0 : host_sda;
  int err_count = 0;
  int compares = 0;

  hof_formatter uut (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_scl(ctl_scl), .ctl_sda_in(sda_wire),
    .ctl_sda_out(ctl_sda_out), .ctl_sda_oe(ctl_sda_oe), .pix_data(pix_data), .pix_small_pd(pix_small_pd),
    .pix_flicker(pix_flicker), .pix_sof(pix_sof), .pix_eol(pix_eol), .pix_eof(pix_eol),
    .pix_row_kind(pix_row_kind), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .four_capture_mode(four_capture_mode), .second_frame_mode(second_frame_mode), .lane_mode(lane_mode),
    .lane_byte(lane_byte), .lane_index(lane_index), .lane_valid(lane_valid), .link_clk_out(link_clk_out),
    .flicker_replace_en(flicker_replace_en));
  hof_rx_model rx (.clk_sys(clk_sys), .lane_byte(lane_byte), .lane_index(lane_index), .lane_valid(lane_valid));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic lost;
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data moves two cycles into the low phase, clear of the pin syncs
  task automatic bit_x(input logic b, output logic r);
    ctl_scl = 1'b0;
    cyc(2);
    host_sda = b;
    cyc(2);
    ctl_scl = 1'b1;
    cyc(4);
    r = sda_wire;
  endtask
  task automatic start_c;
    logic r;
    bit_x(1'b1, r);
    host_sda = 1'b0;
    cyc(4);
  endtask
  task automatic stop_c;
    logic r;
    bit_x(1'b0, r);
    host_sda = 1'b1;
    cyc(4);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(1'b1, ack);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    start_c();
    xfer(8'h20, r, k);
    chk(k, 1'b0);
    xfer(a[15:8], r, k);
    xfer(a[7:0], r, k);
    xfer(d, r, k);
    chk(k, 1'b0);
    stop_c();
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic k;
    start_c();
    xfer(8'h20, r, k);
    xfer(a[15:8], r, k);
    xfer(a[7:0], r, k);
    start_c();
    xfer(8'h21, r, k);
    xfer(8'hFF, r, k);
    stop_c();
    chk(r, e);
  endtask
  task automatic send_row(input logic [23:0] d);
    int n;
    for (int i = 0; i < 1924; i++) begin
      pix_data = d;
      pix_valid = 1'b1;
      pix_sof = (i == 0);
      pix_eol = (i == 1923);
      n = 0;
      while (pix_ready !== 1'b1 && n < 5000) begin
        cyc(1);
        n++;
      end
      if (n >= 5000) lost();
      cyc(1);
    end
    pix_valid = 1'b0;
    pix_eol = 1'b0;
  endtask
  task automatic wait_bytes(input int total);
    int n;
    n = 0;
    while (rx.q.size() < total && n < 40000) begin
      cyc(1);
      n++;
    end
    if (n >= 40000) lost();
    cyc(40);
    chk(16'(rx.q.size()), 16'(total));
  endtask

  task automatic t_regs;
    logic [7:0] r;
    logic k;
    rd_reg(`HOF_A_FORMAT, 8'h00);
    rd_reg(`HOF_A_LINK0, 8'h04);
    rd_reg(`HOF_A_TOP_EMB, 8'h13);
    rd_reg(`HOF_A_DTEST, 8'h12);
    rd_reg(`HOF_A_KNEE_LAST, 8'h00);
    wr_reg(`HOF_A_BOT_EMB, 8'h3A);
    rd_reg(`HOF_A_BOT_EMB, 8'h3A);
    wr_reg(`HOF_A_KNEE_FIRST, 8'h05);
    rd_reg(`HOF_A_KNEE_FIRST, 8'h05);
    rd_reg(16'h1234, 8'h00);
    start_c();
    xfer(8'h22, r, k);
    stop_c();
    chk(k, 1'b1);
  endtask
  task automatic t_frame_flk;
    // the divider needs a period of at least 2 to make a toggling link clock
    wr_reg(`HOF_A_PERIOD, 8'h02);
    rd_reg(`HOF_A_PERIOD, 8'h02);
    second_frame_mode = 2'h1;
    rx.q.delete();
    send_row(24'h0ABCDE);
    chk(flicker_replace_en, 1'b1);
    wait_bytes(6762);
    chk(rx.q[0], 10'h000);
    chk(rx.q[4], 10'h040);
    chk(rx.q[8], 10'h030);
    chk(rx.q[9], 10'h0CA);
    chk(rx.q[10], 10'h012);
    chk(rx.q[12], 10'h0AB);
    chk(rx.q[13], 10'h0CD);
    chk(rx.q[4824], 10'h06A);
    chk(rx.q[4828], 10'h080);
    chk(rx.q[6754], 10'h001);
    chk(rx.q[6758], 10'h041);
  endtask
  task automatic t_frame_spd;
    wr_reg(`HOF_A_FORMAT, 8'h20);
    four_capture_mode = 1'b1;
    second_frame_mode = 2'h2;
    lane_mode = 2'h2;
    rx.q.delete();
    send_row(24'hFFFFFF);
    chk(flicker_replace_en, 1'b0);
    wait_bytes(5319);
    chk(rx.q[8], 10'h02C);
    chk(rx.q[9], 10'h146);
    chk(rx.q[10], 10'h20B);
    chk(rx.q[2900], 10'h06B);
    chk(rx.q[2902], 10'h209);
    chk(rx.q[2904], 10'h0A9);
    chk(rx.q[2905], 10'h1AA);
    chk(rx.q[5311], 10'h001);
  endtask
  task automatic t_frame_wide;
    wr_reg(`HOF_A_FORMAT, 8'h40);
    four_capture_mode = 1'b1;
    second_frame_mode = 2'h0;
    lane_mode = 2'h1;
    pix_row_kind = 3'h2;
    rx.q.delete();
    send_row(24'h123456);
    wait_bytes(5786);
    chk(rx.q[4], 10'h03A);
    chk(rx.q[5], 10'h18C);
    chk(rx.q[8], 10'h056);
    chk(rx.q[9], 10'h134);
    chk(rx.q[5782], 10'h001);
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    cyc(4);
    t_regs();
    t_frame_flk();
    t_frame_spd();
    t_frame_wide();
    stop_test();
  end
endmodule
